// file: ccf_bridge.sv
// Behaviour
// - A Type 1 config read to the secondary bus is claimed and sent on as a Type 0 read.
// - A Type 1 config read to a deeper bus behind the bridge is claimed and sent as Type 1.
// - A non-special Type 1 config write to the secondary bus is claimed and sent as Type 0.
// - A non-special Type 1 config write to a deeper bus is claimed and sent unchanged.
// - A config write to device 1Fh function 7h on the secondary bus becomes a special cycle.
// - Such a special-cycle write to a deeper bus is claimed and sent on as a Type 1 write.
// - Command 1100, memory read multiple, is recognised and forwarded.
// - Command 1101, dual address cycle, is accepted so that 64-bit addresses are forwarded.
// - Memory read line is claimed exactly as an ordinary memory read.
// - Command 1111, memory write and invalidate, is claimed exactly as a memory read.
`include "ccf_consts.svh"

module ccf_bridge
	import ccf_pkg::*;
(
	// Clock, reset and enable.
	input logic clock,
	input logic resetn,
	input logic clkEn,
	// Primary side request.
	input logic reqValid,
	input ccf_cmd_t reqCmd,
	input logic [31:0] reqAddr,
	output logic reqReady,
	output logic reqClaimed,
	output logic reqIgnored,
	// Bridge bus numbers and memory window.
	input logic [7:0] secBus,
	input logic [7:0] subBus,
	input logic [31:0] memBase,
	input logic [31:0] memLimit,
	// Secondary side forward.
	output logic fwdValid,
	input logic fwdReady,
	output ccf_cmd_t fwdCmd,
	output logic [63:0] fwdAddr,
	output logic fwdDac,
	output ccf_kind_e fwdKind
);
	ccf_dec_if dec();
	ccf_state_e stateQ;
	ccf_state_e stateD;
	ccf_cmd_t cmdQ;
	ccf_cmd_t cmdD;
	logic [63:0] addrQ;
	logic [63:0] addrD;
	logic dacQ;
	logic dacD;
	ccf_kind_e kindQ;
	ccf_kind_e kindD;
	logic [31:0] loQ;
	logic [31:0] loD;
	logic claimQ;
	logic claimD;
	logic ignQ;
	logic ignD;

	////////////////////////////////////////////////////////////////////////////
	// Single-address decode.
	assign dec.cmd = reqCmd;
	assign dec.addr = reqAddr;
	assign dec.secBus = secBus;
	assign dec.subBus = subBus;
	assign dec.memBase = memBase;
	assign dec.memLimit = memLimit;

	ccf_decoder uDecoder (
		.dec(dec.decoder)
	);

	////////////////////////////////////////////////////////////////////////////
	// Handshake and data outputs.
	assign reqReady = stateQ != CCF_HOLD;
	assign fwdValid = stateQ == CCF_HOLD;
	assign fwdCmd = cmdQ;
	assign fwdAddr = addrQ;
	assign fwdDac = dacQ;
	assign fwdKind = kindQ;
	assign reqClaimed = claimQ;
	assign reqIgnored = ignQ;

	////////////////////////////////////////////////////////////////////////////
	// Next state of the claim and forward sequencer.
	always_comb begin
		stateD = stateQ;
		cmdD = cmdQ;
		addrD = addrQ;
		dacD = dacQ;
		kindD = kindQ;
		loD = loQ;
		claimD = 1'b0;
		ignD = 1'b0;
		case (stateQ)
			CCF_IDLE: begin
				if (reqValid) begin
					if (reqCmd == `CCF_CMD_DUAL_ADDR) begin
						loD = reqAddr;
						stateD = CCF_DAC_HI;
					end else if (dec.kind != CCF_IGNORE) begin
						cmdD = dec.outCmd;
						addrD = {32'h0, dec.outAddr};
						dacD = 1'b0;
						kindD = dec.kind;
						claimD = 1'b1;
						stateD = CCF_HOLD;
					end else begin
						ignD = 1'b1;
					end
				end
			end
			CCF_DAC_HI: begin
				if (reqValid) begin
					if (ccf_is_mem(reqCmd)) begin
						cmdD = reqCmd;
						addrD = {reqAddr, loQ};
						dacD = 1'b1;
						kindD = CCF_MEM;
						claimD = 1'b1;
						stateD = CCF_HOLD;
					end else begin
						ignD = 1'b1;
						stateD = CCF_IDLE;
					end
				end
			end
			CCF_HOLD: begin
				if (fwdReady) begin
					stateD = CCF_IDLE;
				end
			end
			default: begin
				stateD = CCF_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer registers.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			stateQ <= CCF_IDLE;
			cmdQ <= `CCF_CMD_RST;
			addrQ <= `CCF_ADDR_RST;
			dacQ <= 1'b0;
			kindQ <= CCF_IGNORE;
			loQ <= `CCF_LO_RST;
			claimQ <= 1'b0;
			ignQ <= 1'b0;
		end else if (clkEn) begin
			stateQ <= stateD;
			cmdQ <= cmdD;
			addrQ <= addrD;
			dacQ <= dacD;
			kindQ <= kindD;
			loQ <= loD;
			claimQ <= claimD;
			ignQ <= ignD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	logic accIdle;
	logic accHi;
	logic [7:0] reqBus;
	logic reqT1;
	logic reqSpec;
	logic reqOnSec;
	logic reqBelow;
	logic reqInWin;

	assign accIdle = reqValid && reqReady && clkEn && stateQ == CCF_IDLE;
	assign accHi = reqValid && reqReady && clkEn && stateQ == CCF_DAC_HI;
	assign reqBus = reqAddr[`CCF_BUS_MSB:`CCF_BUS_LSB];
	assign reqT1 = reqAddr[`CCF_TYPE_MSB:`CCF_TYPE_LSB] == `CCF_TYPE1;
	assign reqSpec = reqAddr[`CCF_DEV_MSB:`CCF_DEV_LSB] == `CCF_SPECIAL_DEV &&
		reqAddr[`CCF_FUNC_MSB:`CCF_FUNC_LSB] == `CCF_SPECIAL_FUNC;
	assign reqOnSec = reqBus == secBus;
	assign reqBelow = reqBus > secBus && reqBus <= subBus;
	assign reqInWin = reqAddr >= memBase && reqAddr <= memLimit;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	AST_CFG_RD_TYPE0:
	assert property (accIdle && reqCmd == `CCF_CMD_CFG_RD && reqT1 && reqOnSec
		|=> fwdValid && reqClaimed && fwdCmd == `CCF_CMD_CFG_RD &&
		fwdAddr[1:0] == `CCF_TYPE0 && fwdKind == CCF_CFG0 &&
		fwdAddr[`CCF_REG_MSB:`CCF_REG_LSB] == $past(reqAddr[`CCF_REG_MSB:`CCF_REG_LSB]))
		else $error("Type 1 read to secondary bus not sent as Type 0.");

	AST_CFG_RD_TYPE1:
	assert property (accIdle && reqCmd == `CCF_CMD_CFG_RD && reqT1 && reqBelow
		|=> fwdValid && fwdCmd == `CCF_CMD_CFG_RD && fwdKind == CCF_CFG1 &&
		fwdAddr[31:0] == $past(reqAddr) && !fwdDac)
		else $error("Type 1 read to deeper bus not passed as Type 1.");

	AST_CFG_WR_TYPE0:
	assert property (accIdle && reqCmd == `CCF_CMD_CFG_WR && reqT1 && !reqSpec && reqOnSec
		|=> fwdValid && fwdCmd == `CCF_CMD_CFG_WR && fwdKind == CCF_CFG0 &&
		fwdAddr[1:0] == `CCF_TYPE0)
		else $error("Type 1 write to secondary bus not sent as Type 0.");

	AST_CFG_WR_TYPE1:
	assert property (accIdle && reqCmd == `CCF_CMD_CFG_WR && reqT1 && !reqSpec && reqBelow
		|=> fwdValid && fwdCmd == `CCF_CMD_CFG_WR && fwdAddr[31:0] == $past(reqAddr) &&
		fwdKind == CCF_CFG1)
		else $error("Type 1 write to deeper bus was altered.");

	AST_SPECIAL_SEC:
	assert property (accIdle && reqCmd == `CCF_CMD_CFG_WR && reqT1 && reqSpec && reqOnSec
		|=> fwdValid && fwdCmd == `CCF_CMD_SPECIAL && fwdKind == CCF_SPECIAL)
		else $error("Special-cycle request on secondary bus not turned into a special cycle.");

	AST_SPECIAL_BELOW:
	assert property (accIdle && reqCmd == `CCF_CMD_CFG_WR && reqT1 && reqSpec && reqBelow
		|=> fwdValid && fwdCmd == `CCF_CMD_CFG_WR && fwdKind == CCF_CFG1 &&
		fwdAddr[31:0] == $past(reqAddr))
		else $error("Special-cycle request to deeper bus not passed as Type 1 write.");

	AST_MEM_RD_MULT:
	assert property (accIdle && reqCmd == `CCF_CMD_MEM_RD_MULT && reqInWin
		|=> fwdValid && reqClaimed && fwdCmd == `CCF_CMD_MEM_RD_MULT && fwdKind == CCF_MEM)
		else $error("Memory read multiple not forwarded.");

	property pDualAddr;
		accIdle && reqCmd == `CCF_CMD_DUAL_ADDR ##1
		(stateQ == CCF_DAC_HI && reqValid && clkEn && ccf_is_mem(reqCmd))
		|=> fwdValid && fwdDac && fwdAddr[63:32] == $past(reqAddr) &&
		fwdAddr[31:0] == $past(reqAddr, 2);
	endproperty

	AST_DUAL_ADDR:
	assert property (pDualAddr)
		else $error("Dual address cycle not forwarded with its 64-bit address.");

	AST_DUAL_ADDR_WAIT:
	assert property (accIdle && reqCmd == `CCF_CMD_DUAL_ADDR
		|=> stateQ == CCF_DAC_HI && !fwdValid && !reqClaimed && !reqIgnored)
		else $error("Dual address cycle did not wait for its high address.");

	AST_MEM_RD_LINE:
	assert property (accIdle && (reqCmd == `CCF_CMD_MEM_RD_LINE || reqCmd == `CCF_CMD_MEM_RD)
		|=> reqClaimed == $past(reqInWin) && reqIgnored == !$past(reqInWin))
		else $error("Memory read line claimed differently from memory read.");

	AST_MEM_WR_INV:
	assert property (accIdle && reqCmd == `CCF_CMD_MEM_WR_INV
		|=> reqClaimed == $past(reqInWin) && (!reqClaimed || fwdCmd == `CCF_CMD_MEM_WR_INV))
		else $error("Memory write and invalidate claimed differently from memory read.");

	AST_CFG_OUTSIDE:
	assert property (accIdle && (reqCmd == `CCF_CMD_CFG_RD || reqCmd == `CCF_CMD_CFG_WR) &&
		!reqOnSec && !reqBelow
		|=> reqIgnored && !reqClaimed && !fwdValid)
		else $error("Configuration cycle to an outside bus was claimed.");

	AST_HOLD_STABLE:
	assert property (fwdValid && !(fwdReady && clkEn)
		|=> fwdValid && $stable(fwdAddr) && $stable(fwdCmd) && !reqReady)
		else $error("Forwarded transaction changed before it was taken.");

	AST_FREEZE:
	assert property (!clkEn |=> $stable(stateQ) && $stable(fwdAddr) && $stable(reqClaimed) &&
		$stable(reqIgnored))
		else $error("State moved while the clock enable was low.");

	COV_TYPE0: cover property (accIdle && reqCmd == `CCF_CMD_CFG_RD && reqT1 && reqOnSec);
	COV_SPECIAL: cover property (accIdle && reqCmd == `CCF_CMD_CFG_WR && reqT1 && reqSpec);
	COV_DAC: cover property (fwdValid && fwdDac);
	COV_IGNORE: cover property (reqIgnored);
endmodule : ccf_bridge

// file: ccf_consts.svh
`ifndef CCF_CONSTS_SVH
`define CCF_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Bus command codes.
`define CCF_CMD_SPECIAL 4'h1
`define CCF_CMD_MEM_RD 4'h6
`define CCF_CMD_MEM_WR 4'h7
`define CCF_CMD_CFG_RD 4'ha
`define CCF_CMD_CFG_WR 4'hb
`define CCF_CMD_MEM_RD_MULT 4'hc
`define CCF_CMD_DUAL_ADDR 4'hd
`define CCF_CMD_MEM_RD_LINE 4'he
`define CCF_CMD_MEM_WR_INV 4'hf

////////////////////////////////////////////////////////////////////////////////
// Configuration address fields.
`define CCF_TYPE_MSB 1
`define CCF_TYPE_LSB 0
`define CCF_TYPE0 2'h0
`define CCF_TYPE1 2'h1
`define CCF_BUS_MSB 23
`define CCF_BUS_LSB 16
`define CCF_DEV_MSB 15
`define CCF_DEV_LSB 11
`define CCF_FUNC_MSB 10
`define CCF_FUNC_LSB 8
`define CCF_REG_MSB 10
`define CCF_REG_LSB 2
`define CCF_IDSEL_LSB 16
`define CCF_IDSEL_CNT 16
`define CCF_SPECIAL_DEV 5'h1f
`define CCF_SPECIAL_FUNC 3'h7

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define CCF_CMD_RST 4'h0
`define CCF_ADDR_RST 64'h0
`define CCF_LO_RST 32'h0

`endif

// file: ccf_dec_if.sv
interface ccf_dec_if;
	import ccf_pkg::*;
	ccf_cmd_t cmd;
	logic [31:0] addr;
	logic [7:0] secBus;
	logic [7:0] subBus;
	logic [31:0] memBase;
	logic [31:0] memLimit;
	ccf_kind_e kind;
	ccf_cmd_t outCmd;
	logic [31:0] outAddr;
	modport requester (output cmd, addr, secBus, subBus, memBase, memLimit,
		input kind, outCmd, outAddr);
	modport decoder (input cmd, addr, secBus, subBus, memBase, memLimit,
		output kind, outCmd, outAddr);
endinterface : ccf_dec_if

// file: ccf_decoder.sv
`include "ccf_consts.svh"

module ccf_decoder
	import ccf_pkg::*;
(
	// Decode request and result.
	ccf_dec_if.decoder dec
);
	logic [7:0] bus;
	logic isType1;
	logic onSec;
	logic below;
	logic isSpecial;
	logic inWindow;

	assign bus = dec.addr[`CCF_BUS_MSB:`CCF_BUS_LSB];
	assign isType1 = dec.addr[`CCF_TYPE_MSB:`CCF_TYPE_LSB] == `CCF_TYPE1;
	assign onSec = bus == dec.secBus;
	assign below = bus > dec.secBus && bus <= dec.subBus;
	assign isSpecial = dec.addr[`CCF_DEV_MSB:`CCF_DEV_LSB] == `CCF_SPECIAL_DEV &&
		dec.addr[`CCF_FUNC_MSB:`CCF_FUNC_LSB] == `CCF_SPECIAL_FUNC;
	assign inWindow = dec.addr >= dec.memBase && dec.addr <= dec.memLimit;

	////////////////////////////////////////////////////////////////////////////
	// Classifies one single-address request.
	always_comb begin
		dec.kind = CCF_IGNORE;
		dec.outCmd = dec.cmd;
		dec.outAddr = dec.addr;
		case (dec.cmd)
			`CCF_CMD_CFG_RD: begin
				if (isType1 && onSec) begin
					dec.kind = CCF_CFG0;
					dec.outAddr = ccf_type0_addr(dec.addr);
				end else if (isType1 && below) begin
					dec.kind = CCF_CFG1;
				end
			end
			`CCF_CMD_CFG_WR: begin
				if (isType1 && isSpecial && onSec) begin
					dec.kind = CCF_SPECIAL;
					dec.outCmd = `CCF_CMD_SPECIAL;
					dec.outAddr = 32'h0;
				end else if (isType1 && isSpecial && below) begin
					dec.kind = CCF_CFG1;
				end else if (isType1 && onSec) begin
					dec.kind = CCF_CFG0;
					dec.outAddr = ccf_type0_addr(dec.addr);
				end else if (isType1 && below) begin
					dec.kind = CCF_CFG1;
				end
			end
			default: begin
				if (ccf_is_mem(dec.cmd) && inWindow) begin
					dec.kind = CCF_MEM;
				end
			end
		endcase
	end
endmodule : ccf_decoder

// file: ccf_pkg.sv
`include "ccf_consts.svh"

package ccf_pkg;
	typedef logic [3:0] ccf_cmd_t;
	typedef enum logic [2:0] {
		CCF_IGNORE = 3'h0,
		CCF_CFG0 = 3'h1,
		CCF_CFG1 = 3'h2,
		CCF_SPECIAL = 3'h3,
		CCF_MEM = 3'h4
	} ccf_kind_e;
	typedef enum logic [1:0] {
		CCF_IDLE = 2'h0,
		CCF_HOLD = 2'h1,
		CCF_DAC_HI = 2'h2
	} ccf_state_e;

	function automatic logic ccf_is_mem(input ccf_cmd_t cmd);
		return cmd == `CCF_CMD_MEM_RD || cmd == `CCF_CMD_MEM_WR ||
			cmd == `CCF_CMD_MEM_RD_MULT || cmd == `CCF_CMD_MEM_RD_LINE ||
			cmd == `CCF_CMD_MEM_WR_INV;
	endfunction : ccf_is_mem

	function automatic logic [31:0] ccf_type0_addr(input logic [31:0] addr);
		logic [31:0] res;
		logic [4:0] dev;
		res = 32'h0;
		dev = addr[`CCF_DEV_MSB:`CCF_DEV_LSB];
		res[`CCF_REG_MSB:`CCF_REG_LSB] = addr[`CCF_REG_MSB:`CCF_REG_LSB];
		if (dev < 5'h10) begin
			res[`CCF_IDSEL_LSB + 32'(dev)] = 1'b1;
		end
		return res;
	endfunction : ccf_type0_addr
endpackage : ccf_pkg

// file: ccf_sec_model.sv
////////////////////////////////////////////////////////////////////////////////
// Secondary side target that takes each forward after a chosen number of cycles.
module ccf_sec_model (
	// Clock and reset.
	input wire logic clock,
	input wire logic resetn,
	// Forward handshake.
	input wire logic fwdValid,
	output logic fwdReady,
	// Cycles to wait before accepting.
	input wire logic [3:0] stall
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] waitCnt;

	// Ready is a one-cycle pulse and is never raised without a pending forward.
	always @(posedge clock) begin
		if (!resetn) begin
			fwdReady <= 1'b0;
			waitCnt <= 4'h0;
		end else if (fwdValid && !fwdReady && waitCnt >= stall) begin
			fwdReady <= 1'b1;
		end else begin
			fwdReady <= 1'b0;
			waitCnt <= (fwdValid && !fwdReady) ? waitCnt + 4'h1 : 4'h0;
		end
	end
endmodule : ccf_sec_model

// file: tb_ccf_bridge.sv
`include "ccf_consts.svh"

module tb_ccf_bridge;
	import ccf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic clkEn = 1'b1;
	logic reqValid = 1'b0;
	ccf_cmd_t reqCmd = 4'h0;
	logic [31:0] reqAddr = 32'h0;
	logic [7:0] secBus = 8'h05;
	logic [7:0] subBus = 8'h09;
	logic [31:0] memBase = 32'h1000_0000;
	logic [31:0] memLimit = 32'h1fff_ffff;
	logic [3:0] stall = 4'h0;
	logic reqReady, reqClaimed, reqIgnored, fwdValid, fwdReady, fwdDac;
	ccf_cmd_t fwdCmd;
	logic [63:0] fwdAddr;
	ccf_kind_e fwdKind;
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;

	always #2 clock = ~clock;

	ccf_bridge dut (.clock(clock), .resetn(resetn), .clkEn(clkEn), .reqValid(reqValid),
		.reqCmd(reqCmd), .reqAddr(reqAddr), .reqReady(reqReady), .reqClaimed(reqClaimed),
		.reqIgnored(reqIgnored), .secBus(secBus), .subBus(subBus), .memBase(memBase),
		.memLimit(memLimit), .fwdValid(fwdValid), .fwdReady(fwdReady), .fwdCmd(fwdCmd),
		.fwdAddr(fwdAddr), .fwdDac(fwdDac), .fwdKind(fwdKind));

	ccf_sec_model sec (.clock(clock), .resetn(resetn), .fwdValid(fwdValid),
		.fwdReady(fwdReady), .stall(stall));

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] cfg(input logic [7:0] bus, input logic [4:0] dev,
		input logic [2:0] fn, input logic [1:0] typ);
		return {8'h00, bus, dev, fn, 6'h2a, typ};
	endfunction : cfg

	function automatic logic [31:0] t0(input logic [4:0] dev, input logic [2:0] fn);
		return (32'h1 << (dev + 32'd16)) | {21'h0, fn, 6'h2a, 2'h0};
	endfunction : t0

	// Presents one beat and returns at the edge that takes it.
	task automatic beat(input ccf_cmd_t c, input logic [31:0] a);
		int n;
		reqValid <= 1'b1;
		reqCmd <= c;
		reqAddr <= a;
		n = 0;
		@(negedge clock);
		while (reqReady !== 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		check("reqReady", reqReady, 1'b1);
		@(posedge clock);
	endtask : beat

	// Judges the answer to the taken request and waits for the forward to go.
	task automatic finish_req(input logic claim, input ccf_cmd_t eCmd, input logic [63:0] eAddr,
		input ccf_kind_e eKind, input logic eDac);
		int n;
		reqValid <= 1'b0;
		@(negedge clock);
		check("reqClaimed", reqClaimed, claim);
		check("reqIgnored", reqIgnored, !claim);
		if (claim) begin
			check("fwdValid", fwdValid, 1'b1);
			check("reqReady busy", reqReady, 1'b0);
			check("fwdAddr", fwdAddr, eAddr);
			check("fwdKind", fwdKind, eKind);
			check("fwdDac", fwdDac, eDac);
			n = 0;
			while (fwdValid === 1'b1 && n < 40) begin
				check("fwdCmd", fwdCmd, eCmd);
				@(negedge clock);
				n++;
			end
			check("fwdValid done", fwdValid, 1'b0);
		end
		@(posedge clock);
	endtask : finish_req

	task automatic op(input ccf_cmd_t c, input logic [31:0] a, input logic claim,
		input ccf_cmd_t eCmd, input logic [31:0] eAddr, input ccf_kind_e eKind);
		beat(c, a);
		finish_req(claim, eCmd, {32'h0, eAddr}, eKind, 1'b0);
	endtask : op

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_cfg_read;
		logic [31:0] a;
		a = cfg(8'h05, 5'h03, 3'h2, 2'h1);
		op(`CCF_CMD_CFG_RD, a, 1, `CCF_CMD_CFG_RD, t0(5'h03, 3'h2), CCF_CFG0);
		stall <= 4'h3;
		a = cfg(8'h09, 5'h04, 3'h1, 2'h1);
		op(`CCF_CMD_CFG_RD, a, 1, `CCF_CMD_CFG_RD, a, CCF_CFG1);
	endtask : t_cfg_read

	task automatic t_cfg_write;
		logic [31:0] a;
		stall <= 4'h0;
		a = cfg(8'h05, 5'h0f, 3'h0, 2'h1);
		op(`CCF_CMD_CFG_WR, a, 1, `CCF_CMD_CFG_WR, t0(5'h0f, 3'h0), CCF_CFG0);
		stall <= 4'h2;
		a = cfg(8'h06, 5'h1f, 3'h6, 2'h1);
		op(`CCF_CMD_CFG_WR, a, 1, `CCF_CMD_CFG_WR, a, CCF_CFG1);
	endtask : t_cfg_write

	task automatic t_special;
		logic [31:0] a;
		a = cfg(8'h05, 5'h1f, 3'h7, 2'h1);
		op(`CCF_CMD_CFG_WR, a, 1, `CCF_CMD_SPECIAL, 32'h0, CCF_SPECIAL);
		a = cfg(8'h07, 5'h1f, 3'h7, 2'h1);
		op(`CCF_CMD_CFG_WR, a, 1, `CCF_CMD_CFG_WR, a, CCF_CFG1);
	endtask : t_special

	task automatic t_mem;
		ccf_cmd_t cmds[5] = '{`CCF_CMD_MEM_RD, `CCF_CMD_MEM_WR, `CCF_CMD_MEM_RD_MULT,
			`CCF_CMD_MEM_RD_LINE, `CCF_CMD_MEM_WR_INV};
		stall <= 4'h1;
		foreach (cmds[i]) begin
			op(cmds[i], memLimit, 1, cmds[i], memLimit, CCF_MEM);
			op(cmds[i], memBase - 32'h1, 0, 4'h0, 32'h0, CCF_IGNORE);
		end
	endtask : t_mem

	task automatic t_dac;
		beat(`CCF_CMD_DUAL_ADDR, 32'h8765_4320);
		beat(`CCF_CMD_MEM_RD, 32'h0000_00a5);
		finish_req(1, `CCF_CMD_MEM_RD, 64'h0000_00a5_8765_4320, CCF_MEM, 1);
		beat(`CCF_CMD_DUAL_ADDR, 32'h0000_1000);
		beat(`CCF_CMD_CFG_RD, 32'h0000_0001);
		finish_req(0, 4'h0, 64'h0, CCF_IGNORE, 0);
	endtask : t_dac

	task automatic t_ignore;
		op(`CCF_CMD_CFG_RD, cfg(8'h04, 5'h01, 3'h0, 2'h1), 0, 4'h0, 32'h0, CCF_IGNORE);
		op(`CCF_CMD_CFG_WR, cfg(8'h0a, 5'h01, 3'h0, 2'h1), 0, 4'h0, 32'h0, CCF_IGNORE);
		op(`CCF_CMD_CFG_RD, cfg(8'h05, 5'h01, 3'h0, 2'h0), 0, 4'h0, 32'h0, CCF_IGNORE);
	endtask : t_ignore

	// Freezes a pending forward with the enable low, then resets in mid-run.
	task automatic t_clken;
		logic [31:0] a;
		int n;
		a = cfg(8'h08, 5'h02, 3'h0, 2'h1);
		stall <= 4'h0;
		beat(`CCF_CMD_CFG_RD, a);
		reqValid <= 1'b0;
		clkEn <= 1'b0;
		repeat (4) begin
			@(negedge clock);
			check("frozen reqClaimed", reqClaimed, 1'b1);
			check("frozen fwdAddr", fwdAddr, {32'h0, a});
		end
		@(posedge clock);
		clkEn <= 1'b1;
		n = 0;
		while (fwdValid === 1'b1 && n < 20) begin
			@(negedge clock);
			n++;
		end
		check("thawed fwdValid", fwdValid, 1'b0);
		check("thawed reqClaimed", reqClaimed, 1'b0);
		@(posedge clock);
		beat(`CCF_CMD_CFG_RD, a);
		reqValid <= 1'b0;
		resetn <= 1'b0;
		@(negedge clock);
		check("claim before reset", reqClaimed, 1'b1);
		@(negedge clock);
		check("mid reset fwdValid", fwdValid, 1'b0);
		check("mid reset reqReady", reqReady, 1'b1);
		check("mid reset reqClaimed", reqClaimed, 1'b0);
		check("mid reset fwdAddr", fwdAddr, 64'h0);
		@(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		op(`CCF_CMD_CFG_RD, a, 1, `CCF_CMD_CFG_RD, a, CCF_CFG1);
	endtask : t_clken

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		repeat (7) @(posedge clock);
		@(negedge clock);
		check("reset fwdValid", fwdValid, 1'b0);
		check("reset reqReady", reqReady, 1'b1);
		check("reset fwdKind", fwdKind, CCF_IGNORE);
		@(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		t_cfg_read();
		t_cfg_write();
		t_special();
		t_mem();
		t_dac();
		t_ignore();
		t_clken();
		close_out();
	end
endmodule : tb_ccf_bridge
